// [rtl/burner_demand_priority_select.sv]
// Burner demand priority selector with space heating on/off demand and an Avalon-MM register slave.
//
// The address map and the Avalon-MM slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "demand_select_cfg.svh"

// Function
// (RQ1) Frost guard only when no other demand
// (RQ2) Storage countdown reloads under pump demand
// (RQ3) Priority countdown reloads without pump demand
// (RQ4) Evaluation starts off with skip cleared
// (RQ5) Hot water wins while priority countdown runs
// (RQ6) Space heating chosen when enabled and pumping
// (RQ7) Lead-lag command outranks space heating
// (RQ8) Hot water replaces only by higher priority
// (RQ9) Storage countdown selects hot water
// (RQ10) Frost guard chosen from either enabled demand
// (RQ11) Skip flag when hot water outranks others
// (RQ12) Rate limited, then manual, then sequencing
// (RQ13) Demand rises below setpoint minus hysteresis
// (RQ14) Demand holds until above setpoint plus hysteresis
// (RQ15) Demand switch has four encoded choices
// (RQ16) Burner demand needs sensor demand
// (RQ17) Sensor only: pump follows burner demand
// (RQ18) Thermostat gates pump and burner demand
// (RQ19) Limit chain gates pump and burner demand
// (RQ20) Temperature from outlet, inlet or header
// (RQ21) Frost guard fires at minimum rate
// (RQ22) Five-value result, re-evaluated every tick
module burner_demand_priority_select import demand_select_pkg::*; #(
    parameter int TICK_CYCLES = `TICK_CYCLES,
    parameter int TW = 16,
    parameter int RW = 8
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // Avalon-MM slave
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Demand inputs from neighbouring logic
    input wire logic hot_water_pump_demand,
    input wire logic lead_lag_command_exists,
    input wire logic sh_frost_burner_demand,
    input wire logic hw_frost_burner_demand,
    // Switch pins
    input wire logic thermostat_pin,
    input wire logic limit_chain_input,
    input wire logic remote_stat_pin,
    // Temperatures
    input wire logic [15:0] outlet_temp,
    input wire logic [15:0] inlet_temp,
    input wire logic [15:0] header_temp,
    // Requested rates and overrides
    input wire logic [RW-1:0] sh_rate,
    input wire logic [RW-1:0] hw_rate,
    input wire logic [RW-1:0] ll_rate,
    input wire logic rate_limit_active,
    input wire logic [RW-1:0] rate_limit,
    input wire logic seq_override_active,
    input wire logic [RW-1:0] seq_override_rate,
    // Results for burner sequencing
    output source_t selected_source,
    output logic skip_short_cycle_flag,
    output logic sh_burner_demand,
    output logic sh_pump_demand,
    output logic [RW-1:0] firing_rate
);

    localparam int CW = $clog2(TICK_CYCLES + 1);

    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic [2:0] sync1;
        logic [2:0] sync2;
        logic [CW-1:0] tick_cnt;
        logic tick;
        logic [31:0] ctrl;
        logic [31:0] prio;
        logic [31:0] times;
        logic [31:0] setpoint;
        logic [31:0] hyst;
        logic [31:0] rate;
        logic sens_dem;
        source_t src;
        logic skip;
        logic sh_burner;
        logic sh_pump;
        logic [RW-1:0] frate;
        logic waitreq;
        logic [31:0] rdata;
    } state_t;

    state_t s_q;
    state_t s_d;

    logic [TW-1:0] store_cnt;
    logic [TW-1:0] prio_cnt;

    // ------------------------------------------------------------------------
    // Hot water countdowns
    // ------------------------------------------------------------------------
    countdown_timer #(.W(TW)) u_store_timer (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .tick(s_q.tick),
        .reload(hot_water_pump_demand), // [RQ2]
        .load_value(s_q.times[TW-1:0]),
        .count(store_cnt)
    );

    countdown_timer #(.W(TW)) u_prio_timer (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .tick(s_q.tick),
        .reload(!hot_water_pump_demand), // [RQ3]
        .load_value(s_q.times[16+TW-1:16]),
        .count(prio_cnt)
    );

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] be, input logic [31:0] mask);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[8*i +: 8] = wd[8*i +: 8];
            end
        end
        return r & mask;
    endfunction

    // ------------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------------
    logic sh_en, hw_en, ll_en, store_en, shf_en, hwf_en, man_en, hw_dem, skip_c, sw_on;
    logic [7:0] sh_p, hw_p, ll_p;
    logic [16:0] temp, sp, on_lvl, off_lvl;
    source_t sel;
    switch_t sw_mode;
    logic [RW-1:0] base;

    always_comb begin
        s_d = s_q;
        sh_en = s_q.ctrl[`CTRL_SH_EN];
        hw_en = s_q.ctrl[`CTRL_HW_EN];
        ll_en = s_q.ctrl[`CTRL_LL_EN];
        store_en = s_q.ctrl[`CTRL_STORE_EN];
        shf_en = s_q.ctrl[`CTRL_SH_FROST_EN];
        hwf_en = s_q.ctrl[`CTRL_HW_FROST_EN];
        man_en = s_q.ctrl[`CTRL_MANUAL_EN];
        sw_mode = switch_t'(s_q.ctrl[`CTRL_SWITCH_LSB +: 2]);
        sh_p = s_q.prio[7:0];
        hw_p = s_q.prio[15:8];
        ll_p = s_q.prio[23:16];

        // Pins cross into this domain through two flops.
        s_d.sync1 = {remote_stat_pin, limit_chain_input, thermostat_pin};
        s_d.sync2 = s_q.sync1;

        // Control tick divider.
        s_d.tick = 1'b0;
        if (s_q.tick_cnt == CW'(TICK_CYCLES - 1)) begin
            s_d.tick_cnt = '0;
            s_d.tick = 1'b1;
        end else begin
            s_d.tick_cnt = s_q.tick_cnt + CW'(1);
        end

        // Space heating temperature source and hysteresis band.
        case (sensor_t'(s_q.ctrl[`CTRL_SENSOR_LSB +: 2])) // [RQ20]
            sens_inlet: temp = {1'b0, inlet_temp};
            sens_header: temp = {1'b0, header_temp};
            default: temp = {1'b0, outlet_temp};
        endcase
        sp = {1'b0, s_q.setpoint[15:0]};
        on_lvl = sp - {1'b0, s_q.hyst[15:0]};
        off_lvl = sp + {1'b0, s_q.hyst[31:16]};
        // A hysteresis larger than the setpoint wraps; clamp so demand cannot latch on spuriously.
        if ({1'b0, s_q.hyst[15:0]} > sp) begin
            on_lvl = '0;
        end
        if (temp < on_lvl) begin
            s_d.sens_dem = 1'b1; // [RQ13]
        end else if (temp > off_lvl) begin
            s_d.sens_dem = 1'b0; // [RQ14]
        end

        // Demand switch gating.
        case (sw_mode) // [RQ15]
            sw_thermostat: sw_on = s_q.sync2[0]; // [RQ18]
            sw_limit_chain: sw_on = s_q.sync2[1]; // [RQ19]
            sw_remote_stat: sw_on = s_q.sync2[2];
            default: sw_on = 1'b1;
        endcase
        s_d.sh_burner = s_q.sens_dem && sw_on; // [RQ16] [RQ14]
        if (sw_mode == sw_sensor_only) begin
            s_d.sh_pump = s_q.sh_burner; // [RQ17]
        end else begin
            s_d.sh_pump = sw_on; // [RQ18] [RQ19]
        end

        // Priority evaluation.
        sel = src_off; // [RQ4]
        skip_c = 1'b0; // [RQ4]
        hw_dem = hw_en && hot_water_pump_demand;
        if (hw_dem && prio_cnt != '0) begin
            sel = src_hot_water; // [RQ5]
        end
        if (sel == src_off) begin
            if (sh_en && s_q.sh_pump) begin
                sel = src_space_heat; // [RQ6]
            end
            if (ll_en && lead_lag_command_exists) begin
                sel = src_lead_lag; // [RQ7]
            end
            if (hw_dem) begin
                if (sel == src_space_heat) begin
                    if (hw_p > sh_p) begin
                        sel = src_hot_water; // [RQ8]
                    end
                end else if (sel == src_lead_lag) begin
                    if (hw_p > ll_p) begin
                        sel = src_hot_water; // [RQ8]
                    end
                end else begin
                    sel = src_hot_water; // [RQ8]
                end
            end
        end
        if (sel == src_off && store_en && store_cnt != '0) begin
            sel = src_hot_water; // [RQ9]
        end
        if (sel == src_off) begin
            if ((shf_en && sh_frost_burner_demand) || (hwf_en && hw_frost_burner_demand)) begin
                sel = src_frost; // [RQ10] [RQ1]
            end
        end
        if (sel == src_hot_water) begin
            if (prio_cnt != '0 || ((!sh_en || hw_p > sh_p) && (!ll_en || hw_p > ll_p))) begin
                skip_c = 1'b1; // [RQ11]
            end
        end
        if (s_q.tick) begin
            s_d.src = sel; // [RQ22]
            s_d.skip = skip_c;
        end

        // Firing rate: source, then limiting, then manual, then sequencing.
        case (s_q.src)
            src_space_heat: base = sh_rate;
            src_hot_water: base = hw_rate;
            src_lead_lag: base = ll_rate;
            src_frost: base = s_q.rate[RW-1:0]; // [RQ21]
            default: base = '0;
        endcase
        if (rate_limit_active && s_q.src != src_frost && base > rate_limit) begin
            base = rate_limit; // [RQ12]
        end
        if (man_en) begin
            base = s_q.rate[8 +: RW]; // [RQ12]
        end
        if (seq_override_active) begin
            base = seq_override_rate; // [RQ12]
        end
        s_d.frate = base;

        // Avalon slave: one wait cycle, then the access completes.
        s_d.waitreq = 1'b1;
        if ((avs_read || avs_write) && s_q.waitreq) begin
            s_d.waitreq = 1'b0;
            case (avs_address)
                `OFS_CTRL: s_d.rdata = s_q.ctrl;
                `OFS_PRIO: s_d.rdata = s_q.prio;
                `OFS_TIMES: s_d.rdata = s_q.times;
                `OFS_SETPOINT: s_d.rdata = s_q.setpoint;
                `OFS_HYST: s_d.rdata = s_q.hyst;
                `OFS_RATE: s_d.rdata = s_q.rate;
                `OFS_STATUS: s_d.rdata = {26'h0000000, s_q.sh_pump, s_q.sh_burner, s_q.skip, s_q.src};
                `OFS_TIMERS: s_d.rdata = {16'(prio_cnt), 16'(store_cnt)};
                default: s_d.rdata = 32'h00000000;
            endcase
        end
        if (avs_write && !s_q.waitreq) begin
            case (avs_address)
                `OFS_CTRL: s_d.ctrl = merge(s_q.ctrl, avs_writedata, avs_byteenable, `MASK_CTRL);
                `OFS_PRIO: s_d.prio = merge(s_q.prio, avs_writedata, avs_byteenable, `MASK_PRIO);
                `OFS_TIMES: s_d.times = merge(s_q.times, avs_writedata, avs_byteenable, `MASK_FULL);
                `OFS_SETPOINT: s_d.setpoint = merge(s_q.setpoint, avs_writedata, avs_byteenable, `MASK_RATE);
                `OFS_HYST: s_d.hyst = merge(s_q.hyst, avs_writedata, avs_byteenable, `MASK_FULL);
                `OFS_RATE: s_d.rate = merge(s_q.rate, avs_writedata, avs_byteenable, `MASK_RATE);
                default: s_d.rdata = s_q.rdata;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            s_q <= '0;
            s_q.ctrl <= `RST_CTRL;
            s_q.prio <= `RST_PRIO;
            s_q.times <= `RST_TIMES;
            s_q.setpoint <= `RST_SETPOINT;
            s_q.hyst <= `RST_HYST;
            s_q.rate <= `RST_RATE;
            s_q.src <= src_off;
            s_q.waitreq <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign avs_readdata = s_q.rdata;
    assign avs_waitrequest = s_q.waitreq;
    assign selected_source = s_q.src;
    assign skip_short_cycle_flag = s_q.skip;
    assign sh_burner_demand = s_q.sh_burner;
    assign sh_pump_demand = s_q.sh_pump;
    assign firing_rate = s_q.frate;

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    property p_frost_last;
        @(posedge ref_clk) disable iff (!nrst)
        s_q.tick && ((hw_en && hot_water_pump_demand) || (sh_en && s_q.sh_pump)
            || (ll_en && lead_lag_command_exists)) |=> selected_source != src_frost;
    endproperty
    a_frost_last: assert property (p_frost_last) else $error("frost guard chosen over demand"); // [RQ1]

    property p_store_reload;
        @(posedge ref_clk) disable iff (!nrst)
        hot_water_pump_demand |=> store_cnt == $past(s_q.times[TW-1:0]);
    endproperty
    a_store_reload: assert property (p_store_reload) else $error("storage countdown not reloaded"); // [RQ2]

    property p_prio_count;
        @(posedge ref_clk) disable iff (!nrst)
        hot_water_pump_demand && $past(hot_water_pump_demand) && s_q.tick && prio_cnt != '0
            |=> prio_cnt == $past(prio_cnt) - TW'(1);
    endproperty
    a_prio_count: assert property (p_prio_count) else $error("priority countdown did not step"); // [RQ3]

    property p_hw_first;
        @(posedge ref_clk) disable iff (!nrst)
        s_q.tick && hw_en && hot_water_pump_demand && prio_cnt != '0
            |=> selected_source == src_hot_water && skip_short_cycle_flag;
    endproperty
    a_hw_first: assert property (p_hw_first) else $error("hot water not chosen during priority"); // [RQ5]

    property p_ll_over_sh;
        @(posedge ref_clk) disable iff (!nrst)
        s_q.tick && !hw_en && ll_en && lead_lag_command_exists |=> selected_source == src_lead_lag;
    endproperty
    a_ll_over_sh: assert property (p_ll_over_sh) else $error("lead-lag not chosen"); // [RQ7]

    property p_skip_hw_only;
        @(posedge ref_clk) disable iff (!nrst)
        selected_source != src_hot_water |-> !skip_short_cycle_flag;
    endproperty
    a_skip_hw_only: assert property (p_skip_hw_only) else $error("skip flag without hot water"); // [RQ11]

    property p_sensor_rise;
        @(posedge ref_clk) disable iff (!nrst)
        temp < on_lvl |=> s_q.sens_dem ##1 (sh_burner_demand == sw_on || $changed(sw_on));
    endproperty
    a_sensor_rise: assert property (p_sensor_rise) else $error("demand not raised below band"); // [RQ13]

    property p_stat_off;
        @(posedge ref_clk) disable iff (!nrst)
        sw_mode == sw_thermostat && !s_q.sync2[0] && $stable(sw_mode) |=> !sh_pump_demand && !sh_burner_demand;
    endproperty
    a_stat_off: assert property (p_stat_off) else $error("demand with thermostat off"); // [RQ18]

    property p_frost_rate;
        @(posedge ref_clk) disable iff (!nrst)
        s_q.src == src_frost && !man_en && !seq_override_active |=> firing_rate == $past(s_q.rate[RW-1:0]);
    endproperty
    a_frost_rate: assert property (p_frost_rate) else $error("frost rate not minimum"); // [RQ21]

    c_hw_preempt: cover property (@(posedge ref_clk) disable iff (!nrst)
        selected_source == src_space_heat ##1 selected_source == src_hot_water);
    c_frost: cover property (@(posedge ref_clk) disable iff (!nrst) selected_source == src_frost);
    c_skip: cover property (@(posedge ref_clk) disable iff (!nrst) $rose(skip_short_cycle_flag));

endmodule
`default_nettype wire

// [inc/demand_select_cfg.svh]
// Register offsets, field positions, reset values and timing counts of the demand selector.
`ifndef DEMAND_SELECT_CFG_SVH
`define DEMAND_SELECT_CFG_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define OFS_CTRL 5'h00
`define OFS_PRIO 5'h04
`define OFS_TIMES 5'h08
`define OFS_SETPOINT 5'h0C
`define OFS_HYST 5'h10
`define OFS_RATE 5'h14
`define OFS_STATUS 5'h18
`define OFS_TIMERS 5'h1C

// ----------------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------------
`define CTRL_SH_EN 0
`define CTRL_HW_EN 1
`define CTRL_LL_EN 2
`define CTRL_STORE_EN 3
`define CTRL_SH_FROST_EN 4
`define CTRL_HW_FROST_EN 5
`define CTRL_MANUAL_EN 6
`define CTRL_SWITCH_LSB 8
`define CTRL_SENSOR_LSB 10

// ----------------------------------------------------------------------------
// Writable bit masks and reset values
// ----------------------------------------------------------------------------
`define MASK_CTRL 32'h00000F7F
`define MASK_PRIO 32'h00FFFFFF
`define MASK_FULL 32'hFFFFFFFF
`define MASK_RATE 32'h0000FFFF
`define RST_CTRL 32'h00000000
`define RST_PRIO 32'h00000000
`define RST_TIMES 32'h00000000
`define RST_SETPOINT 32'h00000000
`define RST_HYST 32'h00000000
`define RST_RATE 32'h00000000

// ----------------------------------------------------------------------------
// Control tick timing
// ----------------------------------------------------------------------------
`define REF_CLK_HZ 10000000
`define TICK_PERIOD_US 100000
`define TICK_CYCLES ((`TICK_PERIOD_US) * (`REF_CLK_HZ / 1000000))

`endif

// [inc/demand_select_pkg.sv]
// Types shared by the burner demand selector and its countdown timers.
`default_nettype none
package demand_select_pkg;

    // Source that currently owns the burner.
    typedef enum logic [2:0] {
        src_off,
        src_space_heat,
        src_hot_water,
        src_lead_lag,
        src_frost
    } source_t;

    // Input that gates space heating demand.
    typedef enum logic [1:0] {
        sw_sensor_only,
        sw_thermostat,
        sw_limit_chain,
        sw_remote_stat
    } switch_t;

    // Temperature feeding the space heating loop.
    typedef enum logic [1:0] {
        sens_outlet,
        sens_inlet,
        sens_header,
        sens_spare
    } sensor_t;

endpackage
`default_nettype wire

// [rtl/countdown_timer.sv]
// Reloadable tick-driven countdown that holds at zero.
`timescale 1ns/1ps
`default_nettype none
module countdown_timer import demand_select_pkg::*; #(
    parameter int W = 16
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // Control
    input wire logic tick,
    input wire logic reload,
    input wire logic [W-1:0] load_value,
    // Count
    output logic [W-1:0] count
);

    typedef struct packed {
        logic [W-1:0] cnt;
    } timer_state_t;

    timer_state_t s_q;
    timer_state_t s_d;

    // Reload wins over the tick so the count never dips while the cause persists.
    always_comb begin
        s_d = s_q;
        if (reload) begin
            s_d.cnt = load_value;
        end else if (tick && s_q.cnt != '0) begin
            s_d.cnt = s_q.cnt - W'(1);
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign count = s_q.cnt;

endmodule
`default_nettype wire

// [testbench/sequencing_model.sv]
// Burner sequencing model that forces the firing rate during purge.
`timescale 1ns/1ps
`default_nettype none
module sequencing_model #(
    parameter logic [7:0] PURGE_RATE = 8'h11
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // Command from the bench
    input wire logic purge_req,
    // Override toward the selector
    output logic ov_on,
    output logic [7:0] ov_rate
);
    // The rate is only meaningful while ov_on is high, so it shows a wrong value otherwise.
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            ov_on <= 1'b0;
            ov_rate <= ~PURGE_RATE;
        end else begin
            ov_on <= purge_req;
            ov_rate <= purge_req ? PURGE_RATE : ~PURGE_RATE;
        end
    end
endmodule
`default_nettype wire

// [testbench/burner_demand_priority_select_bench.sv]
// Self-checking bench for the burner demand priority selector.
`timescale 1ns/1ps
`default_nettype none
`include "demand_select_cfg.svh"
module burner_demand_priority_select_bench import demand_select_pkg::*;;
    logic ref_clk = 0, nrst = 0, rd = 0, wr = 0, hwp = 0, llc = 0, shf = 0, hwf = 0, lim_on = 1, purge = 0;
    logic [4:0] adr = 5'h00;
    logic [3:0] be = 4'hF;
    logic [31:0] wd = 32'h0, rdata;
    logic [2:0] pins = 3'h0;
    logic [15:0] tmp [3] = '{16'h03E8, 16'h03E8, 16'h03E8};
    logic [31:0] avs_rd;
    logic wait_q, skip, shb, shp, ov_on;
    logic [7:0] fr, ov_rate;
    source_t src;
    int error_cnt = 0, compares = 0, cyc = 0;

    burner_demand_priority_select #(.TICK_CYCLES(8)) DUT (.ref_clk(ref_clk), .nrst(nrst),
        .avs_address(adr), .avs_read(rd), .avs_write(wr), .avs_writedata(wd), .avs_byteenable(be),
        .avs_readdata(avs_rd), .avs_waitrequest(wait_q), .hot_water_pump_demand(hwp),
        .lead_lag_command_exists(llc), .sh_frost_burner_demand(shf), .hw_frost_burner_demand(hwf),
        .thermostat_pin(pins[0]), .limit_chain_input(pins[1]), .remote_stat_pin(pins[2]),
        .outlet_temp(tmp[0]), .inlet_temp(tmp[1]), .header_temp(tmp[2]), .sh_rate(8'h80), .hw_rate(8'h90),
        .ll_rate(8'hA0), .rate_limit_active(lim_on), .rate_limit(8'h40), .seq_override_active(ov_on),
        .seq_override_rate(ov_rate), .selected_source(src), .skip_short_cycle_flag(skip),
        .sh_burner_demand(shb), .sh_pump_demand(shp), .firing_rate(fr));
    sequencing_model PARTNER (.ref_clk(ref_clk), .nrst(nrst), .purge_req(purge), .ov_on(ov_on),
        .ov_rate(ov_rate));

    // ------------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------------
    task automatic summarize;
        $display("comparisons %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // The request stands until waitrequest is seen low at a rising edge; read data is taken at that edge.
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        adr <= a;
        wd <= d;
        wr <= w;
        rd <= !w;
        do begin
            @(posedge ref_clk);
        end while (wait_q !== 1'b0);
        rdata = avs_rd;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask
    task automatic sel(input logic [31:0] c, input logic [5:0] e);
        bus(1'b1, `OFS_CTRL, c);
        repeat (30) @(posedge ref_clk);
        bus(1'b0, `OFS_STATUS, 32'h0);
        check(rdata & 32'h3F, {26'h0, e});
        check({26'h0, shp, shb, skip, src}, {26'h0, e});
    endtask

    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 10000) begin
            error_cnt++;
            summarize();
        end
    end

    initial begin
        forever #50 ref_clk = ~ref_clk;
    end

    initial begin
        repeat (4) @(posedge ref_clk);
        nrst <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            bus(1'b0, 5'(i * 4), 32'h0);
            check(rdata, 32'h0);
        end
        bus(1'b0, 5'h01, 32'h0);
        check(rdata, 32'h0);
        bus(1'b1, `OFS_CTRL, 32'hFFFFFFFF);
        bus(1'b0, `OFS_CTRL, 32'h0);
        check(rdata, 32'h00000F7F);
        be <= 4'h2;
        bus(1'b1, `OFS_PRIO, 32'hFFFFFFFF);
        be <= 4'hF;
        bus(1'b0, `OFS_PRIO, 32'h0);
        check(rdata, 32'h0000FF00);
        $display("test registers done");
        bus(1'b1, `OFS_TIMES, 32'h00030005);
        repeat (20) @(posedge ref_clk);
        bus(1'b0, `OFS_TIMERS, 32'h0);
        check(rdata, 32'h00030000);
        hwp <= 1'b1;
        repeat (40) @(posedge ref_clk);
        bus(1'b0, `OFS_TIMERS, 32'h0);
        check(rdata, 32'h00000005);
        hwp <= 1'b0;
        repeat (60) @(posedge ref_clk);
        bus(1'b0, `OFS_TIMERS, 32'h0);
        check(rdata, 32'h00030000);
        $display("test timers done");
        bus(1'b1, `OFS_TIMES, 32'h0);
        bus(1'b1, `OFS_SETPOINT, 32'h1F4);
        pins <= 3'h1;
        sel(32'h101, 6'h21);
        check({24'h0, fr}, 32'h40);
        lim_on <= 1'b0;
        repeat (3) @(posedge ref_clk);
        check({24'h0, fr}, 32'h80);
        lim_on <= 1'b1;
        llc <= 1'b1;
        sel(32'h105, 6'h23);
        hwp <= 1'b1;
        bus(1'b1, `OFS_PRIO, 32'h050200);
        sel(32'h107, 6'h23);
        bus(1'b1, `OFS_PRIO, 32'h050900);
        sel(32'h107, 6'h2A);
        bus(1'b1, `OFS_PRIO, 32'h050914);
        sel(32'h107, 6'h22);
        bus(1'b1, `OFS_TIMES, 32'h00C80000);
        hwp <= 1'b0;
        bus(1'b1, `OFS_PRIO, 32'h0);
        repeat (20) @(posedge ref_clk);
        hwp <= 1'b1;
        sel(32'h107, 6'h2A);
        bus(1'b1, `OFS_TIMES, 32'h00000010);
        repeat (20) @(posedge ref_clk);
        hwp <= 1'b0;
        sel(32'h008, 6'h0A);
        $display("test selection done");
        bus(1'b1, `OFS_RATE, 32'h5533);
        shf <= 1'b1;
        sel(32'h010, 6'h04);
        check({24'h0, fr}, 32'h33);
        sel(32'h050, 6'h04);
        check({24'h0, fr}, 32'h55);
        shf <= 1'b0;
        hwf <= 1'b1;
        sel(32'h020, 6'h04);
        sel(32'h121, 6'h21);
        purge <= 1'b1;
        repeat (10) @(posedge ref_clk);
        check({24'h0, fr}, 32'h11);
        purge <= 1'b0;
        $display("test frost and override done");
        pins <= 3'h0;
        bus(1'b1, `OFS_HYST, 32'h0014000A);
        for (int s = 0; s < 3; s++) begin
            tmp <= '{16'h03E8, 16'h03E8, 16'h03E8};
            tmp[s] <= 16'h01E9;
            sel(32'h001 | (s << 10), 6'h31);
        end
        tmp <= '{16'h01E9, 16'h03E8, 16'h03E8};
        sel(32'h001, 6'h31);
        tmp[0] <= 16'h0203;
        sel(32'h001, 6'h31);
        tmp[0] <= 16'h0209;
        sel(32'h001, 6'h00);
        tmp[0] <= 16'h01EF;
        sel(32'h001, 6'h00);
        tmp[0] <= 16'h01E9;
        for (int m = 1; m < 4; m++) begin
            pins <= 3'h0;
            sel(32'h001 | (m << 8), 6'h00);
            pins <= 3'(1 << (m - 1));
            sel(32'h001 | (m << 8), 6'h31);
        end
        $display("test space heating demand done");
        summarize();
    end
endmodule
`default_nettype wire
